//--- emf_pkg.sv
// shared constants, types and register map of the enclave filter
package emf_pkg;
  localparam int GPR_W = 64;
  localparam int APB_AW = 12;
  localparam int REG_NUM = 12;
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_AEP_LO = 4'h2;
  localparam logic [3:0] REG_AEP_HI = 4'h3;
  localparam logic [3:0] REG_TCP_LO = 4'h4;
  localparam logic [3:0] REG_TCP_HI = 4'h5;
  localparam logic [3:0] REG_URSP_LO = 4'h6;
  localparam logic [3:0] REG_URSP_HI = 4'h7;
  localparam logic [3:0] REG_URBP_LO = 4'h8;
  localparam logic [3:0] REG_URBP_HI = 4'h9;
  localparam logic [3:0] REG_CURRENT_SAVE_SLOT = 4'ha;
  localparam logic [3:0] REG_EXITCNT = 4'hb;
  localparam int CTRL_GEN2 = 0;
  localparam int CTRL_PRM = 1;
  localparam int CTRL_TSD = 2;
  localparam int CTRL_TSC_EXIT = 3;
  localparam int CTRL_RAND_EXIT = 4;
  localparam int CTRL_PAUSE_EXIT = 5;
  localparam int CTRL_PLOOP_EXIT = 6;
  localparam int CTRL_W = 7;
  localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam int REASON_ENCL_BIT = 27;
  localparam logic [GPR_W-1:0] RESUME_LEAF = 64'h0000_0000_0000_0003;
  // carry, parity, aux, zero, sign, overflow, resume
  localparam logic [GPR_W-1:0] FLAGS_CLR = 64'h0000_0000_0001_08d5;
  localparam logic [GPR_W-1:0] LOW32_MASK = 64'h0000_0000_ffff_ffff;
  localparam logic [1:0] CPL_KERNEL = 2'h0;

  typedef enum logic [3:0] {
    EMF_IC_OTHER = 4'h0, EMF_IC_EMUL = 4'h1, EMF_IC_PORTIO = 4'h2,
    EMF_IC_SEGPRIV = 4'h3, EMF_IC_MSW = 4'h4, EMF_IC_ENTER = 4'h5,
    EMF_IC_RESUME = 4'h6, EMF_IC_TSC = 4'h7, EMF_IC_RAND = 4'h8,
    EMF_IC_PAUSE = 4'h9, EMF_IC_INT1 = 4'ha, EMF_IC_INT3 = 4'hb,
    EMF_IC_INVD = 4'hc
  } emf_insn_e;
  typedef enum logic [2:0] {
    EMF_EV_EXTINT = 3'h0, EMF_EV_NMI = 3'h1, EMF_EV_SMI = 3'h2,
    EMF_EV_EXC = 3'h3, EMF_EV_VMEXIT = 3'h4
  } emf_event_e;
  typedef enum logic [1:0] {
    EMF_STK_CUR = 2'h0, EMF_STK_RING = 2'h1, EMF_STK_IST = 2'h2
  } emf_stack_e;
  typedef enum logic [1:0] {
    EMF_ST_IDLE = 2'h0, EMF_ST_SAVE = 2'h1, EMF_ST_LOAD = 2'h2
  } emf_state_e;

  typedef struct packed {
    logic valid;
    emf_insn_e cls;
    logic [1:0] cpl;
    logic guest;
    logic ploop_hit;
  } emf_insn_s;
  typedef struct packed {
    logic ud;
    logic gp;
    logic gp_zero;
    logic vmexit;
    logic reason_encl;
  } emf_chk_s;
  typedef struct packed {
    logic valid;
    emf_event_e kind;
    logic priv_change;
    logic ist_used;
    logic is64;
    logic [GPR_W-1:0] flags;
  } emf_event_s;
  typedef struct packed {
    logic [GPR_W-1:0] rip;
    logic [GPR_W-1:0] rax;
    logic [GPR_W-1:0] rbx;
    logic [GPR_W-1:0] rcx;
    logic [GPR_W-1:0] rsp;
    logic [GPR_W-1:0] rbp;
    logic [GPR_W-1:0] flags;
    logic zero_hi;
    logic reason_encl;
    emf_stack_e stack;
  } emf_syn_s;
endpackage

//--- emf_filter.sv
// enclave-mode instruction filter and asynchronous exit sequencer
//
// Contract
// - cpuid-like emulated group faults undefined, no exit
// - port input/output forms fault undefined in enclave
// - far transfers, segment loads, syscalls fault undefined
// - machine status word store faults undefined
// - enter or resume leaf inside enclave: protection
// - gen2: timestamp legal, timestamp-disable still applies
// - gen1 only: timestamp read faults undefined
// - timestamp read may exit per controls
// - random legal; exits only when control set
// - enclave vm exits set reason bit 27
// - cleared random control: re-run without exit
// - spin hint legal; exits only when control set
// - no spin-loop exit from inside enclave
// - single-step, breakpoint instructions accepted in enclave
// - memory protection on: invalidate faults protection zero
// - exiting events leave enclave before handler
// - save registers before loading synthetic values
// - instruction pointer gets async exit pointer
// - restore stack and frame pointers from entry
// - accumulator, base, count get leaf, page, pointer
// - exit stack chosen as outside enclaves
// - clear arithmetic and resume flags, keep others
// - increment current save slot after saving
// - zero upper registers in 64-bit mode only
`timescale 1ns/100ps
module emf_filter #(
  parameter int CURRENT_SAVE_SLOT_W = 32
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [emf_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic enter_done,
  input wire emf_pkg::emf_insn_s insn,
  output emf_pkg::emf_chk_s chk,
  output logic chk_done,
  input wire emf_pkg::emf_event_s evt,
  output logic save_req,
  output logic [CURRENT_SAVE_SLOT_W-1:0] save_slot,
  input wire logic save_ack,
  output emf_pkg::emf_syn_s syn,
  output logic syn_valid,
  output logic in_enclave
);
  import emf_pkg::*;

  if (CURRENT_SAVE_SLOT_W < 1 || CURRENT_SAVE_SLOT_W > 32) begin : g_bad_current_save_slot_w
    $error("emf_filter: CURRENT_SAVE_SLOT_W must be 1 to 32");
  end

  // apb decode; one wait state so every answer is a flop
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  wire [3:0] reg_idx = paddr[5:2];
  wire addr_ok = (paddr[1:0] == 2'h0) &&
                 (paddr[APB_AW-1:6] == '0) &&
                 (reg_idx < 4'(REG_NUM));
  wire acc_phase = psel & penable & ~pready_q;
  wire wr_take = psel & penable & pready_q & pwrite & ~pslverr_q;
  wire ro_reg = (reg_idx == REG_STATUS) || (reg_idx == REG_EXITCNT);
  wire wr_err = pwrite & ro_reg;

  logic [CTRL_W-1:0] ctrl_q;
  logic [31:0] word_q [2:9];
  logic [CURRENT_SAVE_SLOT_W-1:0] current_save_slot_q;
  logic [31:0] exitcnt_q;
  logic encl_q;
  emf_state_e state_q;
  logic [31:0] rd_w [REG_NUM];

  wire [GPR_W-1:0] async_exit_pointer = {word_q[3], word_q[2]};
  wire [GPR_W-1:0] tcp = {word_q[5], word_q[4]};
  wire [GPR_W-1:0] ursp = {word_q[7], word_q[6]};
  wire [GPR_W-1:0] urbp = {word_q[9], word_q[8]};

  assign rd_w[0] = {25'h0, ctrl_q};
  assign rd_w[1] = {28'h0, save_req, state_q, encl_q};
  assign rd_w[10] = 32'(current_save_slot_q);
  assign rd_w[11] = exitcnt_q;
  genvar gi;
  generate
    for (gi = 2; gi <= 9; gi++) begin : g_word
      assign rd_w[gi] = word_q[gi];
      wire sel_w = wr_take && (reg_idx == 4'(gi));
      always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
          word_q[gi] <= WORD_RST;
        end else if (sel_w) begin
          for (int b = 0; b < 4; b++) begin
            if (pstrb[b]) begin
              word_q[gi][8*b +: 8] <= pwdata[8*b +: 8];
            end
          end
        end
      end
    end
  endgenerate

  wire ctrl_wr = wr_take && (reg_idx == REG_CTRL) && pstrb[0];
  wire current_save_slot_wr = wr_take && (reg_idx == REG_CURRENT_SAVE_SLOT);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= WORD_RST;
    end else begin
      pready_q <= acc_phase;
      pslverr_q <= acc_phase & (~addr_ok | wr_err);
      prdata_q <= (acc_phase & addr_ok & ~pwrite) ? rd_w[reg_idx] : WORD_RST;
    end
  end
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign prdata = prdata_q;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q <= CTRL_RST;
    end else if (ctrl_wr) begin
      ctrl_q <= pwdata[CTRL_W-1:0];
    end
  end

  // instruction checks, one cycle from request to verdict
  wire gen2 = ctrl_q[CTRL_GEN2];
  wire prm_on = ctrl_q[CTRL_PRM];
  wire tsd = ctrl_q[CTRL_TSD];
  wire tsc_ctl = ctrl_q[CTRL_TSC_EXIT];
  wire rand_ctl = ctrl_q[CTRL_RAND_EXIT];
  wire pause_ctl = ctrl_q[CTRL_PAUSE_EXIT];
  wire ploop_ctl = ctrl_q[CTRL_PLOOP_EXIT];
  wire c_emul = insn.cls == EMF_IC_EMUL;
  wire c_pio = insn.cls == EMF_IC_PORTIO;
  wire c_seg = insn.cls == EMF_IC_SEGPRIV;
  wire c_msw = insn.cls == EMF_IC_MSW;
  wire c_nest = (insn.cls == EMF_IC_ENTER) || (insn.cls == EMF_IC_RESUME);
  wire c_tsc = insn.cls == EMF_IC_TSC;
  wire c_rand = insn.cls == EMF_IC_RAND;
  wire c_pause = insn.cls == EMF_IC_PAUSE;
  wire c_invd = insn.cls == EMF_IC_INVD;
  wire user_cpl = insn.cpl != CPL_KERNEL;

  wire ud_tbl = encl_q & (c_emul | c_pio | c_seg | c_msw);
  wire ud_tsc = encl_q & c_tsc & ~gen2;
  wire ud_d = ud_tbl | ud_tsc;
  wire gp_nest = encl_q & c_nest;
  wire gp_tsd = c_tsc & tsd & user_cpl & ~ud_tsc;
  wire gp_invd = c_invd & prm_on;
  wire gp_d = gp_nest | gp_tsd | gp_invd;
  // single-step and breakpoint classes fall through with no fault
  wire fault_d = ud_d | gp_d;
  // controls are read live, so a cleared one lets the retry run
  wire ex_tsc = c_tsc & tsc_ctl;
  wire ex_rand = c_rand & rand_ctl;
  wire ex_pause = c_pause & pause_ctl;
  // spin-loop detection only at kernel level, never in an enclave
  wire ex_ploop = c_pause & insn.ploop_hit & ploop_ctl &
                  ~user_cpl & ~encl_q;
  wire vmx_d = insn.guest & ~fault_d &
               (ex_tsc | ex_rand | ex_pause | ex_ploop);
  emf_chk_s chk_q;
  logic chk_done_q;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      chk_q <= '0;
      chk_done_q <= 1'b0;
    end else begin
      chk_done_q <= insn.valid;
      chk_q.ud <= insn.valid & ud_d;
      chk_q.gp <= insn.valid & gp_d;
      chk_q.gp_zero <= insn.valid & gp_invd;
      chk_q.vmexit <= insn.valid & vmx_d;
      chk_q.reason_encl <= insn.valid & vmx_d & encl_q;
    end
  end
  assign chk = chk_q;
  assign chk_done = chk_done_q;

  // async exit sequencer: save, then load synthetic state
  emf_event_s ev_q;
  emf_syn_s syn_q;
  logic syn_valid_q;
  logic save_req_q;
  wire ev_take = evt.valid & encl_q & (state_q == EMF_ST_IDLE);
  wire save_done = (state_q == EMF_ST_SAVE) & save_ack;
  wire load_now = state_q == EMF_ST_LOAD;
  wire [GPR_W-1:0] md_mask = ev_q.is64 ? '1 : LOW32_MASK;
  emf_stack_e stk_d;
  assign stk_d = ev_q.ist_used ? EMF_STK_IST :
                 (ev_q.priv_change ? EMF_STK_RING : EMF_STK_CUR);

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= EMF_ST_IDLE;
    end else begin
      unique case (state_q)
        EMF_ST_IDLE: begin
          if (ev_take) begin
            state_q <= EMF_ST_SAVE;
          end
        end
        EMF_ST_SAVE: begin
          if (save_ack) begin
            state_q <= EMF_ST_LOAD;
          end
        end
        EMF_ST_LOAD: begin
          state_q <= EMF_ST_IDLE;
        end
        default: begin
          state_q <= EMF_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ev_q <= '0;
      save_req_q <= 1'b0;
    end else begin
      if (ev_take) begin
        ev_q <= evt;
      end
      save_req_q <= ev_take | (save_req_q & ~save_ack);
    end
  end

  // hardware increment wins over a software write in the same cycle
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      current_save_slot_q <= '0;
      exitcnt_q <= WORD_RST;
    end else if (save_done) begin
      current_save_slot_q <= current_save_slot_q + CURRENT_SAVE_SLOT_W'(1);
      exitcnt_q <= exitcnt_q + 32'h1;
    end else if (current_save_slot_wr) begin
      current_save_slot_q <= pwdata[CURRENT_SAVE_SLOT_W-1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      encl_q <= 1'b0;
    end else if (load_now) begin
      encl_q <= 1'b0;
    end else if (enter_done) begin
      encl_q <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      syn_q <= '0;
      syn_valid_q <= 1'b0;
    end else begin
      syn_valid_q <= load_now;
      if (load_now) begin
        syn_q.rip <= async_exit_pointer & md_mask;
        syn_q.rax <= RESUME_LEAF;
        syn_q.rbx <= tcp & md_mask;
        syn_q.rcx <= async_exit_pointer & md_mask;
        syn_q.rsp <= ursp & md_mask;
        syn_q.rbp <= urbp & md_mask;
        syn_q.flags <= ev_q.flags & ~FLAGS_CLR & md_mask;
        syn_q.zero_hi <= ev_q.is64;
        syn_q.reason_encl <= ev_q.kind == EMF_EV_VMEXIT;
        syn_q.stack <= stk_d;
      end
    end
  end
  assign syn = syn_q;
  assign syn_valid = syn_valid_q;
  assign save_req = save_req_q;
  assign save_slot = current_save_slot_q;
  assign in_enclave = encl_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  a_emul_group_ud: assert property (
    insn.valid && encl_q && c_emul |=> chk.ud && !chk.vmexit)
    else $error("emulated group not undefined");
  a_portio_ud: assert property (
    insn.valid && encl_q && c_pio |=> chk_done && chk.ud)
    else $error("port io not undefined");
  a_segpriv_ud: assert property (
    insn.valid && encl_q && c_seg |=> chk.ud && !chk.gp)
    else $error("segment op not undefined");
  a_msw_store_ud: assert property (
    insn.valid && c_msw |=> chk.ud == $past(encl_q))
    else $error("msw store verdict wrong");
  a_nested_entry_gp: assert property (
    insn.valid && encl_q && c_nest |=> chk.gp && !chk.ud)
    else $error("nested entry not protected");
  a_tsc_gen_split: assert property (
    insn.valid && encl_q && c_tsc |=> chk.ud == !$past(gen2))
    else $error("timestamp gen split wrong");
  a_rand_exit_gate: assert property (
    insn.valid && c_rand && insn.guest
    |=> chk.vmexit == $past(rand_ctl) && !chk.ud)
    else $error("random exit gating wrong");
  a_pause_no_loop: assert property (
    insn.valid && encl_q && c_pause && !pause_ctl |=> !chk.vmexit)
    else $error("spin exit from enclave");
  a_reason_bit: assert property (
    chk.reason_encl |-> chk.vmexit && $past(encl_q))
    else $error("reason bit misset");
  a_invd_gp_zero: assert property (
    insn.valid && c_invd && prm_on |=> chk.gp && chk.gp_zero)
    else $error("invalidate not protected");
  a_save_before_load: assert property (
    ev_take |=> save_req[*1] ##0 !syn_valid ##1 !syn_valid)
    else $error("synthetic state before save");
  a_exit_clears_flag: assert property (
    save_done |=> ##1 syn_valid && !encl_q && syn.rip == (async_exit_pointer & md_mask))
    else $error("exit flag or pointer wrong");
  a_flags_cleared: assert property (
    syn_valid |-> (syn.flags & FLAGS_CLR) == '0 && syn.rax == RESUME_LEAF)
    else $error("exit flags not cleared");
  a_slot_increment: assert property (
    save_done |=> current_save_slot_q == $past(current_save_slot_q) + CURRENT_SAVE_SLOT_W'(1))
    else $error("slot not bumped");
  a_fault_no_exit: assert property (
    chk.ud || chk.gp |-> !chk.vmexit)
    else $error("fault together with vm exit");
  a_outside_no_fault: assert property (
    insn.valid && !encl_q && !c_tsc && !c_invd |=> !chk.ud && !chk.gp)
    else $error("enclave fault outside enclave");
  a_hint_legal: assert property (
    insn.valid && (insn.cls == EMF_IC_INT1 || insn.cls == EMF_IC_INT3)
    |=> !chk.ud && !chk.gp)
    else $error("debug hint faulted");
  a_tsd_protect: assert property (
    insn.valid && encl_q && c_tsc && gen2 && tsd && user_cpl
    |=> chk.gp && !chk.ud)
    else $error("timestamp disable ignored");
  a_tsc_exit_gate: assert property (
    insn.valid && encl_q && c_tsc && gen2 && !tsd && insn.guest
    |=> chk.vmexit == $past(tsc_ctl))
    else $error("timestamp exit gating wrong");
  a_pause_exit_gate: assert property (
    insn.valid && c_pause && insn.guest && user_cpl
    |=> chk.vmexit == $past(pause_ctl))
    else $error("spin hint exit gating wrong");
  a_gp_zero_cause: assert property (
    chk.gp_zero |-> chk.gp && !chk.ud)
    else $error("error code zero without protection fault");
  a_ignore_outside: assert property (
    evt.valid && !encl_q && state_q == EMF_ST_IDLE |=> !save_req)
    else $error("exit taken outside enclave");
  a_save_req_holds: assert property (
    save_req && !save_ack |=> save_req)
    else $error("save request dropped early");
  a_ist_stack: assert property (
    syn_valid |-> (syn.stack == EMF_STK_IST) == ev_q.ist_used)
    else $error("stack table choice wrong");
  a_ring_stack: assert property (
    syn_valid && !ev_q.ist_used
    |-> (syn.stack == EMF_STK_RING) == ev_q.priv_change)
    else $error("ring stack choice wrong");
  a_count_pointer: assert property (
    syn_valid |-> syn.rcx == syn.rip && syn.zero_hi == ev_q.is64)
    else $error("count register or upper zeroing wrong");
  a_exit_count: assert property (
    save_done |=> exitcnt_q == $past(exitcnt_q) + 32'h1)
    else $error("exit count not bumped");
  a_enclave_set: assert property (
    enter_done && !load_now |=> encl_q)
    else $error("enclave flag not set on entry");
endmodule // emf_filter

//--- emf_filter_test.sv
// self-checking testbench of the enclave filter and exit sequencer
`timescale 1ns/100ps
module emf_filter_test;
  import emf_pkg::*;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [APB_AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [3:0] pstrb = 4'hf;
  logic pready, pslverr, err, enter_done = 1'b0, save_ack = 1'b0;
  emf_insn_s insn = '0;
  emf_chk_s chk;
  emf_event_s evt = '0;
  emf_syn_s syn, sx;
  logic chk_done, save_req, syn_valid, in_enclave;
  logic [31:0] save_slot;
  int errors = 0, cmp_count = 0, cycles = 0;
  // ctrl, class, expected {ud,gp,gp_zero,vmexit,reason}
  localparam logic [19:0] TBL [20] = '{20'h00_1_10, 20'h7f_1_10,
    20'h00_2_10, 20'h00_3_10, 20'h00_4_10, 20'h00_5_08, 20'h00_6_08,
    20'h00_7_10, 20'h18_7_10, 20'h09_7_03, 20'h05_7_08, 20'h01_7_00,
    20'h10_8_03, 20'h00_8_00, 20'h20_9_03, 20'h40_9_00, 20'h7d_a_00,
    20'h7d_b_00, 20'h02_c_0c, 20'h00_0_00};

  emf_filter #(.CURRENT_SAVE_SLOT_W(32)) emf_filter_inst (.ref_clk(ref_clk),
    .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .enter_done(enter_done),
    .insn(insn), .chk(chk), .chk_done(chk_done), .evt(evt),
    .save_req(save_req), .save_slot(save_slot), .save_ack(save_ack),
    .syn(syn), .syn_valid(syn_valid), .in_enclave(in_enclave));

  always #2 ref_clk = ~ref_clk;

  task automatic wrap_up;
    $display("tests done: %0d compares, %0d errors", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      wrap_up();
    end
  end

  task automatic check(input logic [511:0] got, input logic [511:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // one apb transfer; pready is looked at mid-cycle, where it has settled,
  // and the request is held through the edge that samples it high
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(negedge ref_clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    @(posedge ref_clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic t_regs;
    apb(1'b0, 12'h000, 32'h0);
    check(rd, 32'h0);
    apb(1'b1, 12'h000, 32'h0000_007f);
    apb(1'b0, 12'h000, 32'h0);
    check(rd, 32'h0000_007f);
    apb(1'b0, 12'h030, 32'h0);
    check({rd, err}, {32'h0, 1'b1});
    apb(1'b1, 12'h004, 32'h0000_0001);
    check(err, 1'b1);
    $display("register test done");
  endtask

  task automatic send(input logic [3:0] c, input logic [4:0] exp);
    @(posedge ref_clk);
    insn <= {1'b1, emf_insn_e'(c), 2'h3, 1'b1, 1'b1};
    @(posedge ref_clk);
    insn.valid <= 1'b0;
    @(negedge ref_clk);
    check({chk_done, chk}, {1'b1, exp});
  endtask

  task automatic enter;
    @(posedge ref_clk);
    enter_done <= 1'b1;
    @(posedge ref_clk);
    enter_done <= 1'b0;
    @(posedge ref_clk);
    check(in_enclave, 1'b1);
  endtask

  task automatic t_filter;
    // outside the enclave neither the emulated group nor entry faults
    apb(1'b1, 12'h000, 32'h0);
    send(4'h1, 5'h00);
    send(4'h5, 5'h00);
    enter();
    // sweeps every class: faults, exits, spin-loop and hint legality
    for (int i = 0; i < 20; i++) begin
      apb(1'b1, 12'h000, {24'h0, TBL[i][19:12]});
      send(TBL[i][11:8], TBL[i][4:0]);
    end
    $display("filter test done");
  endtask

  // one asynchronous exit, judged against pointers written earlier
  task automatic t_exit(input emf_event_e k, input logic pc, interrupt_stack_table, is64,
                        input emf_stack_e st, input logic [31:0] slot);
    @(posedge ref_clk);
    evt <= {1'b1, k, pc, interrupt_stack_table, is64, 64'hffff_ffff_ffff_ffff};
    @(posedge ref_clk);
    evt.valid <= 1'b0;
    @(negedge ref_clk);
    check({save_req, syn_valid, save_slot}, {2'b10, slot});
    @(posedge ref_clk);
    save_ack <= 1'b1;
    @(posedge ref_clk);
    save_ack <= 1'b0;
    @(negedge ref_clk);
    check({save_req, syn_valid, in_enclave}, 3'b001);
    @(negedge ref_clk);
    check(syn_valid, 1'b1);
    sx.rip = 64'h1234_5678_9abc_def0;
    sx.rcx = sx.rip;
    sx.rbx = 64'h0fed_cba9_8765_4320;
    sx.rsp = 64'h0000_7ff0_0000_1000;
    sx.rbp = 64'h0000_7ff0_0000_2000;
    sx.flags = ~FLAGS_CLR;
    if (!is64) begin
      sx.rip &= LOW32_MASK;
      sx.rcx &= LOW32_MASK;
      sx.rbx &= LOW32_MASK;
      sx.rsp &= LOW32_MASK;
      sx.rbp &= LOW32_MASK;
      sx.flags &= LOW32_MASK;
    end
    sx.rax = RESUME_LEAF;
    sx.zero_hi = is64;
    sx.reason_encl = (k == EMF_EV_VMEXIT);
    sx.stack = st;
    check(syn, sx);
    check({in_enclave, save_slot}, {1'b0, slot + 32'h1});
    @(negedge ref_clk);
    check(syn_valid, 1'b0);
    $display("exit test done");
  endtask

  task automatic t_ignored;
    @(posedge ref_clk);
    evt <= {1'b1, EMF_EV_NMI, 1'b0, 1'b0, 1'b1, 64'h0};
    @(posedge ref_clk);
    evt.valid <= 1'b0;
    // save_req would rise in the cycle after the take edge
    repeat (2) @(posedge ref_clk);
    check(save_req, 1'b0);
    $display("ignored event test done");
  endtask

  initial begin
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    t_regs();
    t_filter();
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, 12'h008 + 12'(4 * i), i[0] ?
          (i == 1 ? 32'h1234_5678 : i == 3 ? 32'h0fed_cba9 : 32'h0000_7ff0)
          : (i == 0 ? 32'h9abc_def0 : i == 2 ? 32'h8765_4320 :
             i == 4 ? 32'h0000_1000 : 32'h0000_2000));
    end
    t_exit(EMF_EV_VMEXIT, 1'b1, 1'b0, 1'b1, EMF_STK_RING, 32'h0);
    t_ignored();
    enter();
    apb(1'b0, 12'h004, 32'h0);
    check(rd, 32'h1);
    t_exit(EMF_EV_EXTINT, 1'b0, 1'b1, 1'b0, EMF_STK_IST, 32'h1);
    enter();
    t_exit(EMF_EV_EXC, 1'b0, 1'b0, 1'b1, EMF_STK_CUR, 32'h2);
    apb(1'b0, 12'h028, 32'h0);
    check(rd, 32'h3);
    apb(1'b0, 12'h02c, 32'h0);
    check(rd, 32'h3);
    apb(1'b0, 12'h004, 32'h0);
    check(rd, 32'h0);
    wrap_up();
  end
endmodule // emf_filter_test
